//--- pkg/uei_cfg.svh
// Address, field and reset constants for the USB event interrupt enable block.
`ifndef UEI_CFG_SVH
`define UEI_CFG_SVH

// APB address width in bits; word index times four must fit.
`define UEI_ADDR_W      18
// APB data width in bits.
`define UEI_DATA_W      32
// Register word indices; the byte address is four times the index.
`define UEI_IDX_ENABLE  16'hfffd
`define UEI_IDX_STATUS  16'hfff8
`define UEI_IDX_VECTOR  16'hfff9
// Number of bits in each event register.
`define UEI_REG_W       8
// Event bit positions, shared by the status and enable registers.
`define UEI_BIT_RESET   7
`define UEI_BIT_SUSPEND 6
`define UEI_BIT_RESUME  5
`define UEI_BIT_SOF     4
`define UEI_BIT_PSEUDO_FRAME_START_ENABLE    3
`define UEI_BIT_SETUP   2
`define UEI_BIT_RSVD    1
`define UEI_BIT_SETUP_OVERWRITE_ENABLE   0
// Reset values.
`define UEI_ENABLE_RST  8'h00
`define UEI_STATUS_RST  8'h00
// Bits software may write in the enable register; bit 1 stays zero.
`define UEI_ENABLE_WMSK 8'hfd
// Vector code shown when no enabled event is pending.
`define UEI_VEC_NONE    8'h00

`endif

//--- pkg/uei_pkg.sv
// Types shared by the USB event interrupt enable block.
package uei_pkg;

  // One event register, status or enable.
  typedef logic [7:0] uei_byte_t;

  // Bus slave sequencing states, one-hot.
  typedef enum logic [1:0] {
    UEI_ST_IDLE = 2'b01,
    UEI_ST_ACK  = 2'b10
  } uei_apb_st_t;

endpackage

//--- src/uei_event_status.sv
// Sticky USB event status bits with set-over-clear priority.
`timescale 1ns/10ps
`include "uei_cfg.svh"

module uei_event_status #(
  parameter int W = `UEI_REG_W                 // Number of status bits.
) (
  input  wire logic         clk_sys,           // System clock.
  input  wire logic         rst_n,             // Synchronous reset, active low.
  input  wire logic [W-1:0] set_vec,           // One-cycle event pulses.
  input  wire logic [W-1:0] clr_vec,           // Bits software clears.
  output logic      [W-1:0] status_r           // Sticky status bits.
);

  // Next value; a set in the clearing cycle wins so no event is lost.
  logic [W-1:0] status_nxt;                    // Next status value.

  assign status_nxt = set_vec | (status_r & ~clr_vec);

  // Status register, cleared on reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_r <= W'(`UEI_STATUS_RST);
    end else begin
      status_r <= status_nxt;
    end
  end

endmodule

//--- src/uei_apb_port.sv
// APB slave sequencer giving one wait state per transfer.
`timescale 1ns/10ps
`include "uei_cfg.svh"

module uei_apb_port
  import uei_pkg::*;
(
  input  wire logic clk_sys,                   // System clock.
  input  wire logic rst_n,                     // Synchronous reset, active low.
  input  wire logic psel,                      // APB select.
  input  wire logic penable,                   // APB enable.
  output logic      pready_r,                  // APB ready, registered.
  output logic      load_stb,                  // First access cycle, latch answer.
  output logic      done_stb                   // Cycle whose edge completes transfer.
);

  uei_apb_st_t state_r;                        // Current sequencer state.
  uei_apb_st_t state_nxt;                      // Next sequencer state.

  // The first access cycle seen in idle loads the answer for the next edge.
  assign load_stb  = (state_r == UEI_ST_IDLE) & psel & penable;
  // Ready is high in the acknowledge state, so this edge ends the transfer.
  assign done_stb  = (state_r == UEI_ST_ACK) & psel & penable;
  assign state_nxt = load_stb ? UEI_ST_ACK : UEI_ST_IDLE;

  // State and ready flops; ready mirrors the acknowledge state.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r  <= UEI_ST_IDLE;
      pready_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      pready_r <= load_stb;
    end
  end

endmodule

//--- src/uei_top.sv
// USB event interrupt enable register with status, vector and APB access.
//
// Behaviour
// - Each enable bit gates its status bit.
// - Bit 6 enables the suspend interrupt.
// - Bit 3 enables the pseudo frame-start interrupt.
// - Bit 0 enables the setup overwrite interrupt.
// - Bits 7,5,4,2 are read/write interrupt enables.
// - Bit 1 reads zero, ignores writes.
// - Register at index fffd, resets to zero.
// - Events set status; vector write clears them.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`include "uei_cfg.svh"

module uei_top
  import uei_pkg::*;
#(
  parameter int ADDR_W = `UEI_ADDR_W,          // APB address width.
  parameter int DATA_W = `UEI_DATA_W           // APB data width.
) (
  input  wire logic              clk_sys,      // System clock, 100 MHz.
  input  wire logic              rst_n,        // Synchronous reset, active low.
  input  wire logic              psel,         // APB select.
  input  wire logic              penable,      // APB enable.
  input  wire logic              pwrite,       // APB direction, high for write.
  input  wire logic [ADDR_W-1:0] paddr,        // APB byte address.
  input  wire logic [DATA_W-1:0] pwdata,       // APB write data.
  output logic      [DATA_W-1:0] prdata_r,     // APB read data.
  output logic                   pready_r,     // APB ready.
  output logic                   pslverr_r,    // APB error for unmapped address.
  input  wire logic              evt_reset,    // Function reset event pulse.
  input  wire logic              evt_suspend,  // Function suspend event pulse.
  input  wire logic              evt_resume,   // Function resume event pulse.
  input  wire logic              evt_sof,      // Start-of-frame event pulse.
  input  wire logic              evt_pseudo_frame_start_enable,     // Pseudo start-of-frame event pulse.
  input  wire logic              evt_setup,    // Setup stage complete event pulse.
  input  wire logic              evt_setup_overwrite_enable,    // Setup overwrite event pulse.
  output logic                   usb_irq_r     // Combined interrupt request, level.
);

  // Byte address of a register from its word index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // Highest pending gated event as a code: bit position plus one, zero if none.
  function automatic uei_byte_t vec_code(input uei_byte_t pend);
    vec_code = `UEI_VEC_NONE;
    for (int i = 0; i < `UEI_REG_W; i++) begin
      if (pend[i]) begin
        vec_code = uei_byte_t'(i + 1);
      end
    end
  endfunction

  // Enable register and its next value.
  uei_byte_t enable_r;                         // Interrupt enable bits.
  uei_byte_t enable_nxt;                       // Next enable value.
  // Status bits and the software clear request.
  uei_byte_t status_r;                         // Sticky event status.
  uei_byte_t status_clr;                       // Bits cleared this cycle.
  uei_byte_t event_vec;                        // Event pulses packed by position.
  uei_byte_t pending;                          // Status bits that are enabled.
  uei_byte_t rd_word;                          // Register value being read.
  // Read-clear bookkeeping.
  uei_byte_t rd_clr_r;                         // Status bits reported by a read.
  uei_byte_t rd_clr_nxt;                       // Next reported bits.
  // Bus decode.
  logic      load_stb;                         // First access cycle.
  logic      done_stb;                         // Transfer completes at this edge.
  logic      hit_enable;                       // Address selects enable register.
  logic      hit_status;                       // Address selects status register.
  logic      hit_vector;                       // Address selects vector register.
  logic      hit_any;                          // Address is mapped.
  logic      wr_enable;                        // Write to enable register.
  logic      wr_vector;                        // Write to vector register.
  logic      rd_status_done;                   // Completed read of status.
  logic      irq_nxt;                          // Next interrupt level.
  logic [DATA_W-1:0] prdata_nxt;               // Next read data.
  logic      pslverr_nxt;                      // Next error flag.

  // Bus sequencing lives in its own module; it owns the ready flop.
  uei_apb_port u_apb (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .psel     (psel),
    .penable  (penable),
    .pready_r (pready_r),
    .load_stb (load_stb),
    .done_stb (done_stb)
  );

  // Address decode against the three word addresses.
  assign hit_enable = (paddr == reg_addr(`UEI_IDX_ENABLE));
  assign hit_status = (paddr == reg_addr(`UEI_IDX_STATUS));
  assign hit_vector = (paddr == reg_addr(`UEI_IDX_VECTOR));
  assign hit_any    = hit_enable | hit_status | hit_vector;

  // Writes and read side effects act only at the completing edge.
  assign wr_enable      = done_stb & pwrite & hit_enable;
  assign wr_vector      = done_stb & pwrite & hit_vector;
  assign rd_status_done = done_stb & ~pwrite & hit_status;

  // Only writable enable bits take the bus value; the reserved bit stays zero.
  assign enable_nxt = wr_enable
                    ? (pwdata[`UEI_REG_W-1:0] & `UEI_ENABLE_WMSK)
                    : enable_r;

  // Enable register; every interrupt starts disabled.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      enable_r <= `UEI_ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // Event pulses packed by bit position; the reserved slot never sets.
  assign event_vec[`UEI_BIT_RESET]   = evt_reset;
  assign event_vec[`UEI_BIT_SUSPEND] = evt_suspend;
  assign event_vec[`UEI_BIT_RESUME]  = evt_resume;
  assign event_vec[`UEI_BIT_SOF]     = evt_sof;
  assign event_vec[`UEI_BIT_PSEUDO_FRAME_START_ENABLE]    = evt_pseudo_frame_start_enable;
  assign event_vec[`UEI_BIT_SETUP]   = evt_setup;
  assign event_vec[`UEI_BIT_RSVD]    = 1'b0;
  assign event_vec[`UEI_BIT_SETUP_OVERWRITE_ENABLE]   = evt_setup_overwrite_enable;

  // A vector write clears every status bit; a status read clears only the
  // bits it actually reported, so an event landing after the data was
  // latched survives until it is read.
  assign status_clr = (wr_vector ? 8'hff : 8'h00)
                    | (rd_status_done ? rd_clr_r : 8'h00);

  // Sticky status bits; a set in the clearing cycle wins.
  uei_event_status #(
    .W (`UEI_REG_W)
  ) u_status (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .set_vec  (event_vec),
    .clr_vec  (status_clr),
    .status_r (status_r)
  );

  // Gate each status bit by its enable; a masked bit still records its event.
  assign pending = status_r & enable_r;
  assign irq_nxt = |pending;

  // Interrupt level, recomputed on every clock from the gated bits.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      usb_irq_r <= 1'b0;
    end else begin
      usb_irq_r <= irq_nxt;
    end
  end

  // Value returned by a read; the vector shows the highest enabled pending
  // event, so software can service sources without reading status first.
  assign rd_word = hit_enable ? enable_r
                 : hit_status ? status_r
                 : hit_vector ? vec_code(pending)
                 : 8'h00;

  // Read data is latched at the first access cycle and held while ready is
  // high; bits above the register width read as zero.
  assign prdata_nxt = (load_stb & ~pwrite) ? DATA_W'(rd_word) : prdata_r;
  // Unmapped addresses answer with an error in the ready cycle only.
  assign pslverr_nxt = load_stb & ~hit_any;
  // Remember which status bits were handed out, for the read clear.
  assign rd_clr_nxt = (load_stb & ~pwrite & hit_status) ? status_r : rd_clr_r;

  // Read data, error flag and read-clear snapshot.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      rd_clr_r  <= `UEI_STATUS_RST;
    end else begin
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      rd_clr_r  <= rd_clr_nxt;
    end
  end

  // Checks on the gating, the enable register and the bus answer.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // The interrupt follows the gated status one clock later.
  chk_gate_follow: assert property (
    ##1 usb_irq_r == |($past(status_r) & $past(enable_r)))
    else $error("interrupt does not follow gated status");

  // Suspend pending and enabled raises the interrupt next clock.
  chk_suspend_raise: assert property (
    status_r[`UEI_BIT_SUSPEND] && enable_r[`UEI_BIT_SUSPEND] |=> usb_irq_r)
    else $error("suspend enable did not raise interrupt");

  // Pseudo frame-start pending and enabled raises the interrupt.
  chk_pseudo_frame_start_enable_raise: assert property (
    status_r[`UEI_BIT_PSEUDO_FRAME_START_ENABLE] && enable_r[`UEI_BIT_PSEUDO_FRAME_START_ENABLE] |=> usb_irq_r)
    else $error("pseudo frame-start enable did not raise interrupt");

  // Setup overwrite pending and enabled raises the interrupt.
  chk_setup_overwrite_enable_raise: assert property (
    status_r[`UEI_BIT_SETUP_OVERWRITE_ENABLE] && enable_r[`UEI_BIT_SETUP_OVERWRITE_ENABLE] |=> usb_irq_r)
    else $error("setup overwrite enable did not raise interrupt");

  // A write to the enable register stores the writable bits exactly.
  chk_enable_write: assert property (
    wr_enable |=> enable_r == ($past(pwdata[`UEI_REG_W-1:0]) & `UEI_ENABLE_WMSK))
    else $error("enable register did not store written value");

  // The reserved enable bit never reads as one.
  chk_reserved_zero: assert property (
    !enable_r[`UEI_BIT_RSVD] && !status_r[`UEI_BIT_RSVD])
    else $error("reserved bit is set");

  // Reset clears the enables and drops the interrupt.
  chk_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0)
    !rst_n |=> enable_r == `UEI_ENABLE_RST && !usb_irq_r)
    else $error("reset did not clear enables");

  // A suspend event is recorded in status on the next clock.
  chk_event_sticky: assert property (
    evt_suspend |=> status_r[`UEI_BIT_SUSPEND])
    else $error("event not recorded in status");

  // A vector write with no new events leaves status empty.
  chk_vector_clear: assert property (
    wr_vector && event_vec == 8'h00 |=> status_r == 8'h00)
    else $error("vector write did not clear status");

  // Every access is answered with ready exactly one clock after it starts.
  chk_apb_answer: assert property (
    load_stb |=> pready_r ##1 !pready_r)
    else $error("bus answer not given in one wait state");

  // Function reset pending and enabled raises the interrupt.
  chk_func_reset_raise: assert property (
    status_r[`UEI_BIT_RESET] && enable_r[`UEI_BIT_RESET] |=> usb_irq_r)
    else $error("function reset enable did not raise interrupt");

  // Function resume pending and enabled raises the interrupt.
  chk_resume_raise: assert property (
    status_r[`UEI_BIT_RESUME] && enable_r[`UEI_BIT_RESUME] |=> usb_irq_r)
    else $error("resume enable did not raise interrupt");

  // Start-of-frame pending and enabled raises the interrupt.
  chk_sof_raise: assert property (
    status_r[`UEI_BIT_SOF] && enable_r[`UEI_BIT_SOF] |=> usb_irq_r)
    else $error("frame-start enable did not raise interrupt");

  // Setup complete pending and enabled raises the interrupt.
  chk_setup_raise: assert property (
    status_r[`UEI_BIT_SETUP] && enable_r[`UEI_BIT_SETUP] |=> usb_irq_r)
    else $error("setup enable did not raise interrupt");

  // With nothing both pending and enabled, the request stays low.
  chk_masked_quiet: assert property (
    (status_r & enable_r) == 8'h00 |=> !usb_irq_r)
    else $error("interrupt raised with no enabled event pending");

  // Without a completed write the enable register keeps its value.
  chk_enable_hold: assert property (
    !wr_enable |=> $stable(enable_r))
    else $error("enable register changed without a write");

  // Status bits stay set until something clears them.
  chk_status_sticky: assert property (
    status_clr == 8'h00 |=> ($past(status_r) & ~status_r) == 8'h00)
    else $error("status bit dropped without a clear");

  // Every event pulse sets its status bit, even in a clearing cycle.
  chk_event_set_all: assert property (
    event_vec != 8'h00 |=> (status_r & $past(event_vec)) == $past(event_vec))
    else $error("event pulse did not set its status bit");

  // A completed status read clears the bits it reported, barring new events.
  chk_read_clear: assert property (
    rd_status_done && event_vec == 8'h00 |=> (status_r & $past(rd_clr_r)) == 8'h00)
    else $error("status read did not clear reported bits");

  // A write to the read-only status register changes nothing.
  chk_status_write_ignored: assert property (
    done_stb && pwrite && hit_status && event_vec == 8'h00 |=> $stable(status_r))
    else $error("status register changed by a write");

  // An access to an unmapped address is answered with an error.
  chk_error_unmapped: assert property (
    load_stb && !hit_any |=> pready_r && pslverr_r)
    else $error("unmapped access not answered with error");

  // An access to the enable register is answered without an error.
  chk_enable_decode: assert property (
    load_stb && hit_enable |=> pready_r && !pslverr_r)
    else $error("enable register access answered with error");

  // Ready never rises unless an access cycle came before it.
  chk_ready_idle: assert property (
    !(psel && penable) |=> !pready_r)
    else $error("ready raised without an access");

endmodule

//--- tb/test_usb_event_interrupt_mask.sv
// Self-checking bench for the USB event interrupt enable block.
`timescale 1ns/10ps
`include "uei_cfg.svh"

module test_usb_event_interrupt_mask;
  import uei_pkg::*;

  // One expected APB answer, noted by the driver.
  typedef struct {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } uei_note_t;

  localparam logic [17:0] A_EN  = 18'h3fff4;   // Enable register byte address.
  localparam logic [17:0] A_ST  = 18'h3ffe0;   // Status register byte address.
  localparam logic [17:0] A_VEC = 18'h3ffe4;   // Vector register byte address.

  logic        clk_sys;                        // System clock.
  logic        rst_n;                          // Synchronous reset.
  logic        psel;                           // APB select.
  logic        penable;                        // APB enable.
  logic        pwrite;                         // APB direction.
  logic [17:0] paddr;                          // APB address.
  logic [31:0] pwdata;                         // APB write data.
  logic [31:0] prdata_r;                       // APB read data.
  logic        pready_r;                       // APB ready.
  logic        pslverr_r;                      // APB error.
  logic [7:0]  evt;                            // Event pulses by bit position.
  logic        usb_irq_r;                      // Interrupt request.
  uei_note_t   notes[$];                       // Expected answers, oldest first.
  int          mismatches;                     // Mismatch count.
  int          checked;                        // Comparison count.
  logic [31:0] rng;                            // Random generator state.
  logic [7:0]  en;                             // Enable value under test.
  logic [7:0]  ev;                             // Event set under test.

  uei_top uei_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .evt_reset(evt[7]),
    .evt_suspend(evt[6]), .evt_resume(evt[5]), .evt_sof(evt[4]),
    .evt_pseudo_frame_start_enable(evt[3]), .evt_setup(evt[2]), .evt_setup_overwrite_enable(evt[0]),
    .usb_irq_r(usb_irq_r)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Xorshift source; fixed start keeps runs repeatable.
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Compares one value and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer; the master holds everything until pready is seen high.
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    uei_note_t n;
    bit        done;
    n = '{rd: ~wr, data: exp, err: err};
    notes.push_back(n);
    done = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk_sys);
      done = (pready_r === 1'b1);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      mismatches++;
      $display("unexpected timeout waiting for pready");
      give_verdict();
    end
  endtask

  // Pulses a set of events for one cycle, then checks the request level.
  task automatic pulse(input logic [7:0] m, input logic exp);
    @(posedge clk_sys);
    evt <= m;
    @(posedge clk_sys);
    evt <= 8'h00;
    @(posedge clk_sys);
    #1;
    check({31'h0, usb_irq_r}, {31'h0, exp}, "usb_irq_r");
  endtask

  // Monitor: every ready cycle takes the oldest note and compares with it.
  always @(posedge clk_sys) begin
    uei_note_t n;
    if (rst_n === 1'b1 && pready_r === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("unexpected ready with nothing pending");
      end else begin
        n = notes.pop_front();
        if (n.rd) check(prdata_r, n.data, "prdata_r");
        check({31'h0, pslverr_r}, {31'h0, n.err}, "pslverr_r");
      end
    end
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h0; pwdata = 32'h0; evt = 8'h00;
    mismatches = 0; checked = 0; rng = 32'd89777;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values: everything disabled and clear.
    apb(1'b0, A_EN, 32'h0, 32'h0, 1'b0);
    apb(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    #1;
    check({31'h0, usb_irq_r}, 32'h0, "usb_irq_r idle");
    $display("test reset values done");
    // Bit 1 cannot be set; the others read back as written.
    apb(1'b1, A_EN, 32'hffffffff, 32'h0, 1'b0);
    apb(1'b0, A_EN, 32'h0, 32'hfd, 1'b0);
    // Unmapped and read-only places.
    apb(1'b0, 18'h00010, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 18'h00020, 32'hff, 32'h0, 1'b1);
    apb(1'b1, A_ST, 32'hff, 32'h0, 1'b0);
    apb(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    $display("test access kinds done");
    // Each enable alone: only its own event raises the request.
    for (int b = 0; b < 8; b++) begin
      if (b == 1) continue;
      en = 8'h01 << b;
      apb(1'b1, A_EN, {24'h0, en}, 32'h0, 1'b0);
      pulse(8'hfd & ~en, 1'b0);
      apb(1'b0, A_ST, 32'h0, {24'h0, 8'hfd & ~en}, 1'b0);
      pulse(en, 1'b1);
      apb(1'b0, A_VEC, 32'h0, b + 1, 1'b0);
      apb(1'b1, A_VEC, 32'h0, 32'h0, 1'b0);
      @(posedge clk_sys);
      #1;
      check({31'h0, usb_irq_r}, 32'h0, "usb_irq_r cleared");
    end
    $display("test single enables done");
    // Random enable and event mixes.
    for (int k = 0; k < 6; k++) begin
      en = 8'(xs());
      ev = 8'(xs());
      apb(1'b1, A_EN, {24'h0, en}, 32'h0, 1'b0);
      apb(1'b0, A_EN, 32'h0, {24'h0, en & 8'hfd}, 1'b0);
      pulse(ev, |(ev & en & 8'hfd));
      apb(1'b1, A_VEC, 32'h0, 32'h0, 1'b0);
      apb(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    end
    $display("test random mixes done");
    // Reset in mid-run: enables, status and request drop back to zero.
    apb(1'b1, A_EN, 32'h000000ff, 32'h0, 1'b0);
    pulse(8'hff, 1'b1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check({31'h0, usb_irq_r}, 32'h0, "usb_irq_r after reset");
    apb(1'b0, A_EN, 32'h0, 32'h0, 1'b0);
    apb(1'b0, A_ST, 32'h0, 32'h0, 1'b0);
    $display("test mid-run reset done");
    repeat (4) @(posedge clk_sys);
    give_verdict();
  end

endmodule
